// ===== sfpe_params.svh
`ifndef SFPE_PARAMS_SVH
`define SFPE_PARAMS_SVH

// ==========================================================
// Command opcodes
`define SFPE_OP_UNLOCK 8'h06
`define SFPE_OP_WRAP 8'h77
`define SFPE_OP_PROG 8'h02
`define SFPE_OP_QPROG 8'h32
`define SFPE_OP_UNIT 8'h20
`define SFPE_OP_BLK32 8'h52
`define SFPE_OP_BLK64 8'hd8

// ==========================================================
// Frame lengths in whole bytes, opcode included
`define SFPE_LEN_UNLOCK 4'h1
`define SFPE_LEN_ERASE 4'h4
`define SFPE_LEN_WRAP 4'h5
`define SFPE_LEN_PROG_MIN 4'h5

// ==========================================================
// Wrap setting: bits WRAP_SETTING_BITS of the wrap byte, reset value W4=1
`define SFPE_WRAP_LSB 4
`define SFPE_WRAP_RST 3'h1

// ==========================================================
// Region sizes as address bit counts
`define SFPE_PAGE_BITS 8
`define SFPE_SECT_BITS 5'h0c
`define SFPE_BLK32_BITS 5'h0f
`define SFPE_BLK64_BITS 5'h10

// ==========================================================
// Timing
`define SFPE_CLK_NS 10
`define SFPE_PROG_US 600
`define SFPE_UNIT_US 50000
`define SFPE_BLK_US 150000
`define SFPE_US2CYC(t) (((t) * 1000) / `SFPE_CLK_NS)

`endif

// ===== sfpe_pkg.sv
package sfpe_pkg;

    typedef enum logic [1:0] {
        S_IDLE,
        S_PROG,
        S_ERASE,
        S_WAIT
    } sfpe_state_t;

    typedef struct packed {
        logic [7:0] opc;
        logic [3:0] cnt;
        logic [2:0] nb;
        logic [23:0] addr;
        logic [7:0] wrap;
    } sfpe_frame_t;

endpackage

// ===== sfpe_top.sv
`timescale 1ns/1ns
`include "sfpe_params.svh"
module sfpe_top #(
    parameter int MEM_AW = 16,
    parameter int unsigned PROGRAM_CYCLES = 32'(`SFPE_US2CYC(`SFPE_PROG_US)),
    parameter int unsigned UNIT_WIPE_CYCLES = 32'(`SFPE_US2CYC(`SFPE_UNIT_US)),
    parameter int unsigned BLOCK_WIPE_CYCLES = 32'(`SFPE_US2CYC(`SFPE_BLK_US))
) (
    // System
    input wire logic mclk,
    input wire logic srst,
    // Serial link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic [3:0] io_in,
    // Configuration
    input wire logic quad_io_enable,
    input wire logic [4:0] block_protect_bits,
    // Status
    output logic write_in_progress,
    output logic write_enable_latch,
    output logic [2:0] wrap_setting_bits,
    // Read address port
    input wire logic rd_start,
    input wire logic [23:0] rd_start_addr,
    input wire logic rd_next,
    output logic [23:0] rd_addr,
    output logic [7:0] rd_data
);

    if (MEM_AW < 16 || MEM_AW > 24) begin : g_chk
        $error("MEM_AW must lie between 16 and 24.");
    end
    if (PROGRAM_CYCLES < 1 || UNIT_WIPE_CYCLES < 1 || BLOCK_WIPE_CYCLES < 1) begin : g_chk_t
        $error("Cycle counts must be at least one.");
    end

    // ==========================================================
    // Functions

    function automatic logic sfpe_in_prot(input logic [23:0] a, input logic [4:0] bp);
        logic [24:0] sz;
        sz = 25'h1 << ((bp[4] ? 5'h0b : 5'h0f) + {2'h0, bp[2:0]});
        if (bp[2:0] == 3'h0) begin
            return 1'b0;
        end
        if (bp[2:0] == 3'h7) begin
            return 1'b1;
        end
        if (bp[3]) begin
            return {1'b0, a} < sz;
        end
        return {1'b0, a} >= (25'h1000000 - sz);
    endfunction

    function automatic logic [23:0] sfpe_wrap_next(input logic [23:0] a, input logic [2:0] w);
        logic [7:0] m;
        logic [7:0] inc;
        m = 8'((8'h08 << w[2:1]) - 8'h01);
        inc = 8'(a[7:0] + 8'h01);
        if (w[0]) begin
            return 24'(a + 24'h1);
        end
        return {a[23:8], (a[7:0] & ~m) | (inc & m)};
    endfunction

    function automatic logic [23:0] sfpe_span(input logic [4:0] bits);
        return 24'((25'h1 << bits) - 25'h1);
    endfunction

    // ==========================================================
    // Link domain: capture on the rising serial clock

    sfpe_pkg::sfpe_frame_t frm;
    logic in_frame;
    logic [7:0] sh;
    logic [7:0] dptr;
    logic [7:0] pbuf [256];
    logic [255:0] pmask;
    logic busy_l1;
    logic busy_l2;
    logic [2:0] cur_nb;
    logic [3:0] cur_cnt;
    logic quad;
    logic [3:0] next_nb;
    logic [7:0] next_sh;
    logic byte_done;
    logic is_pgm_l;

    // The flag drops the instant select rises, so the frame end needs no serial edge.
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            in_frame <= 1'b0;
        end else begin
            in_frame <= 1'b1;
        end
    end

    always_ff @(posedge sclk) begin
        busy_l1 <= write_in_progress;
        busy_l2 <= busy_l1;
    end

    always_comb begin
        cur_nb = in_frame ? frm.nb : 3'h0;
        cur_cnt = in_frame ? frm.cnt : 4'h0;
        quad = (cur_cnt != 4'h0) && (frm.opc == `SFPE_OP_QPROG);
        next_sh = quad ? {sh[3:0], io_in} : {sh[6:0], io_in[0]};
        next_nb = {1'b0, cur_nb} + (quad ? 4'h4 : 4'h1);
        byte_done = next_nb == 4'h8;
        is_pgm_l = (frm.opc == `SFPE_OP_PROG) || (frm.opc == `SFPE_OP_QPROG);
    end

    always_ff @(posedge sclk) begin
        sh <= next_sh;
        frm.nb <= byte_done ? 3'h0 : next_nb[2:0];
        frm.cnt <= cur_cnt;
        if (byte_done) begin
            frm.cnt <= (cur_cnt == 4'hf) ? cur_cnt : 4'(cur_cnt + 4'h1);
            case (cur_cnt)
                4'h0: frm.opc <= next_sh;
                4'h1: frm.addr[23:16] <= next_sh;
                4'h2: frm.addr[15:8] <= next_sh;
                4'h3: frm.addr[7:0] <= next_sh;
                4'h4: frm.wrap <= next_sh;
                default: ;
            endcase
        end
    end

    // Page data is held off while busy, so a late frame cannot spoil a running program.
    always_ff @(posedge sclk) begin
        if (byte_done && cur_cnt == 4'h3) begin
            dptr <= next_sh;
        end else if (byte_done && cur_cnt >= 4'h4 && is_pgm_l && !busy_l2) begin
            pbuf[dptr] <= next_sh;
            dptr <= 8'(dptr + 8'h01);
        end
    end

    always_ff @(posedge sclk) begin
        if (byte_done && cur_cnt == 4'h0 && !busy_l2) begin
            pmask <= '0;
        end else if (byte_done && cur_cnt >= 4'h4 && is_pgm_l && !busy_l2) begin
            pmask[dptr] <= 1'b1;
        end
    end

    // ==========================================================
    // Frame end crossing into the system clock

    logic inf_m1;
    logic inf_m2;
    logic inf_m3;
    logic fend;

    always_ff @(posedge mclk) begin
        if (srst) begin
            inf_m1 <= 1'b0;
            inf_m2 <= 1'b0;
            inf_m3 <= 1'b0;
        end else begin
            inf_m1 <= in_frame;
            inf_m2 <= inf_m1;
            inf_m3 <= inf_m2;
        end
    end

    // The frame fields are read only after this edge, when the serial clock has stopped.
    assign fend = inf_m3 && !inf_m2;

    // ==========================================================
    // Command decode at frame end

    sfpe_pkg::sfpe_state_t state;
    logic [23:0] lo;
    logic [23:0] hi;
    logic [4:0] rbits;
    logic is_prog;
    logic is_erase;
    logic whole;
    logic go;
    logic write_unlock_command_ev;
    logic wrap_ev;
    logic [31:0] wait_cyc;

    always_comb begin
        whole = fend && (frm.nb == 3'h0) && (state == sfpe_pkg::S_IDLE);
        is_prog = ((frm.opc == `SFPE_OP_PROG) || (frm.opc == `SFPE_OP_QPROG && quad_io_enable))
            && (frm.cnt >= `SFPE_LEN_PROG_MIN);
        is_erase = (frm.cnt == `SFPE_LEN_ERASE) && ((frm.opc == `SFPE_OP_UNIT)
            || (frm.opc == `SFPE_OP_BLK32) || (frm.opc == `SFPE_OP_BLK64));
        case (frm.opc)
            `SFPE_OP_UNIT: rbits = `SFPE_SECT_BITS;
            `SFPE_OP_BLK32: rbits = `SFPE_BLK32_BITS;
            `SFPE_OP_BLK64: rbits = `SFPE_BLK64_BITS;
            default: rbits = 5'(`SFPE_PAGE_BITS);
        endcase
        lo = frm.addr & ~sfpe_span(rbits);
        hi = lo | sfpe_span(rbits);
        go = whole && write_enable_latch && (is_prog || is_erase)
            && !sfpe_in_prot(lo, block_protect_bits)
            && !sfpe_in_prot(hi, block_protect_bits);
        write_unlock_command_ev = whole && frm.cnt == `SFPE_LEN_UNLOCK && frm.opc == `SFPE_OP_UNLOCK;
        wrap_ev = whole && frm.cnt == `SFPE_LEN_WRAP && frm.opc == `SFPE_OP_WRAP;
        if (is_prog) begin
            wait_cyc = PROGRAM_CYCLES;
        end else if (frm.opc == `SFPE_OP_UNIT) begin
            wait_cyc = UNIT_WIPE_CYCLES;
        end else begin
            wait_cyc = BLOCK_WIPE_CYCLES;
        end
    end

    // ==========================================================
    // Self-timed cycle

    logic [23:0] idx;
    logic [23:0] last;
    logic [31:0] timer;

    // Erase clears several bytes a cycle, so a 64KB block does not cost 64K copy cycles.
    // Every erase region is aligned to far more than this many bytes.
    localparam int ERASE_LANES = 8;

    always_ff @(posedge mclk) begin
        if (srst) begin
            state <= sfpe_pkg::S_IDLE;
            idx <= 24'h0;
            last <= 24'h0;
            timer <= 32'h0;
        end else begin
            case (state)
                sfpe_pkg::S_IDLE: begin
                    if (go) begin
                        idx <= lo;
                        last <= hi;
                        timer <= wait_cyc - 32'h1;
                        state <= is_prog ? sfpe_pkg::S_PROG : sfpe_pkg::S_ERASE;
                    end
                end
                sfpe_pkg::S_PROG: begin
                    idx <= 24'(idx + 24'h1);
                    if (idx == last) begin
                        state <= sfpe_pkg::S_WAIT;
                    end
                end
                sfpe_pkg::S_ERASE: begin
                    idx <= 24'(idx + 24'(ERASE_LANES));
                    if (24'(idx + 24'(ERASE_LANES - 1)) == last) begin
                        state <= sfpe_pkg::S_WAIT;
                    end
                end
                sfpe_pkg::S_WAIT: begin
                    timer <= 32'(timer - 32'h1);
                    if (timer == 32'h0) begin
                        state <= sfpe_pkg::S_IDLE;
                    end
                end
                default: state <= sfpe_pkg::S_IDLE;
            endcase
        end
    end

    assign write_in_progress = state != sfpe_pkg::S_IDLE;

    // Clearing at the start of the copy keeps the latch low well before busy drops.
    always_ff @(posedge mclk) begin
        if (srst) begin
            write_enable_latch <= 1'b0;
        end else if (write_unlock_command_ev) begin
            write_enable_latch <= 1'b1;
        end else if (state == sfpe_pkg::S_PROG || state == sfpe_pkg::S_ERASE) begin
            write_enable_latch <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            wrap_setting_bits <= `SFPE_WRAP_RST;
        end else if (wrap_ev) begin
            wrap_setting_bits <= frm.wrap[`SFPE_WRAP_LSB +: 3];
        end
    end

    // ==========================================================
    // Array and read port

    logic [7:0] mem [2**MEM_AW];
    logic [23:0] next_rd_addr;

    always_comb begin
        next_rd_addr = rd_addr;
        if (rd_start) begin
            next_rd_addr = rd_start_addr;
        end else if (rd_next) begin
            next_rd_addr = sfpe_wrap_next(rd_addr, wrap_setting_bits);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            rd_addr <= 24'h0;
        end else begin
            rd_addr <= next_rd_addr;
        end
    end

    always_ff @(posedge mclk) begin
        rd_data <= mem[next_rd_addr[MEM_AW-1:0]];
    end

    // Programming only clears bits, as the cells do; erase sets them back to ones.
    always_ff @(posedge mclk) begin
        if (state == sfpe_pkg::S_PROG && pmask[idx[7:0]]) begin
            mem[idx[MEM_AW-1:0]] <= mem[idx[MEM_AW-1:0]] & pbuf[idx[7:0]];
        end else if (state == sfpe_pkg::S_ERASE) begin
            for (int j = 0; j < ERASE_LANES; j++) begin
                mem[idx[MEM_AW-1:0] + MEM_AW'(j)] <= 8'hff;
            end
        end
    end

endmodule

// ===== sfpe_top_props.sv
`timescale 1ns/1ns
module sfpe_chk (
    // System
    input wire logic mclk,
    input wire logic srst,
    // Link and status
    input wire logic cs_n,
    input wire logic write_in_progress,
    input wire logic write_enable_latch,
    input wire logic [2:0] wrap_setting_bits,
    // Read port
    input wire logic rd_start,
    input wire logic [23:0] rd_start_addr,
    input wire logic rd_next,
    input wire logic [23:0] rd_addr
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    // ====
    // Section mask; only meaningful while the wrap-disable bit is 0.
    logic [23:0] sect_mask;
    assign sect_mask = (24'h8 << wrap_setting_bits[2:1]) - 24'h1;
    sequence s_launch;
        $rose(write_in_progress);
    endsequence
    sequence s_finish;
        $fell(write_in_progress);
    endsequence
    sequence s_wrap_step;
        rd_next && !rd_start && !wrap_setting_bits[0];
    endsequence
    sequence s_line_step;
        rd_next && !rd_start && wrap_setting_bits[0];
    endsequence
    chk_reset_values: assert property (
        $fell(srst) |-> !write_in_progress && !write_enable_latch && wrap_setting_bits == 3'h1)
        else $error("state after reset is wrong");
    chk_start_after_cs: assert property (s_launch |-> cs_n && $past(cs_n, 2))
        else $error("busy rose while select was low");
    chk_busy_holds: assert property (s_launch |-> write_in_progress [*8])
        else $error("busy dropped too early");
    chk_latch_before_end: assert property (s_finish |-> !$past(write_enable_latch))
        else $error("latch still set when busy fell");
    chk_latch_clear_busy: assert property ($fell(write_enable_latch) |-> write_in_progress)
        else $error("latch cleared outside a cycle");
    chk_start_needs_latch: assert property (s_launch |-> $past(write_enable_latch))
        else $error("cycle started with latch clear");
    chk_idle_no_latch: assert property (
        !write_enable_latch && !write_in_progress |=> !write_in_progress)
        else $error("cycle started without latch");
    chk_wrap_change_ok: assert property (
        $changed(wrap_setting_bits) |-> $past(cs_n, 2) && !$past(write_in_progress))
        else $error("wrap setting changed mid frame or busy");
    chk_read_load: assert property (rd_start |=> rd_addr == $past(rd_start_addr))
        else $error("read start address not loaded");
    chk_read_wrap: assert property (s_wrap_step |=> rd_addr ==
        (($past(rd_addr) & ~$past(sect_mask)) | (($past(rd_addr) + 24'h1) & $past(sect_mask))))
        else $error("wrapped read step wrong");
    chk_read_line: assert property (s_line_step |=> rd_addr == $past(rd_addr) + 24'h1)
        else $error("linear read step wrong");
endmodule
bind sfpe_top sfpe_chk u_chk (.mclk(mclk), .srst(srst), .cs_n(cs_n),
    .write_in_progress(write_in_progress), .write_enable_latch(write_enable_latch),
    .wrap_setting_bits(wrap_setting_bits), .rd_start(rd_start), .rd_start_addr(rd_start_addr),
    .rd_next(rd_next), .rd_addr(rd_addr));

// ===== sfpe_host.sv
`timescale 1ns/1ns
module sfpe_host (
    // Serial link
    output logic sclk,
    output logic cs_n,
    output logic [3:0] io_in
);
    logic [7:0] fbytes [0:299];
    initial begin
        sclk = 1'b0;
        cs_n = 1'b0;
        io_in = 4'h0;
        // A rising select at start clears the link-side frame flag, which has no reset.
        #1 cs_n = 1'b1;
    end
    task automatic shift(input logic [3:0] v);
        io_in = v;
        #16 sclk = 1'b1;
        #16 sclk = 1'b0;
    endtask
    // Clock stays still between frames; unused lines toggle on whole bytes so stale values never match, and sit at 0 in a part byte.
    task automatic send(input int nbytes, input int extra, input bit quad);
        int i;
        int b;
        #3 cs_n = 1'b0;
        for (i = 0; i < nbytes; i++) begin
            if (quad && i > 0) begin
                shift(fbytes[i][7:4]);
                shift(fbytes[i][3:0]);
            end else begin
                for (b = 7; b >= 0; b--)
                    shift({~io_in[3:1], fbytes[i][b]});
            end
        end
        for (b = 7; b > 7 - extra; b--)
            shift({3'h0, fbytes[nbytes][b]});
        #16 cs_n = 1'b1;
        io_in = ~io_in;
    endtask
endmodule

// ===== tb_serial_flash_program_erase.sv
`timescale 1ns/1ns
`include "sfpe_params.svh"
module tb_serial_flash_program_erase;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic quad_en = 1'b0;
    logic [4:0] prot = 5'h00;
    logic rd_start = 1'b0;
    logic rd_next = 1'b0;
    logic [23:0] rd_start_addr = 24'h000000;
    logic sclk, cs_n, busy, latch;
    logic [3:0] io_in;
    logic [2:0] wrap_bits;
    logic [23:0] rd_addr;
    logic [7:0] rd_data;
    int error_cnt = 0;
    int n_compared = 0;
    always #5 mclk = ~mclk;
    sfpe_host host (.sclk(sclk), .cs_n(cs_n), .io_in(io_in));
    // Short cycle counts keep the run small; expectations do not depend on them.
    sfpe_top #(.PROGRAM_CYCLES(20), .UNIT_WIPE_CYCLES(20), .BLOCK_WIPE_CYCLES(20)) dut (
        .mclk(mclk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .io_in(io_in),
        .quad_io_enable(quad_en), .block_protect_bits(prot), .write_in_progress(busy),
        .write_enable_latch(latch), .wrap_setting_bits(wrap_bits), .rd_start(rd_start),
        .rd_start_addr(rd_start_addr), .rd_next(rd_next), .rd_addr(rd_addr), .rd_data(rd_data));
    task stop_test();
        if (error_cnt == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task check(input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task send(input logic [7:0] opc, input logic [23:0] a, input int nd, input int ex,
              input bit q);
        host.fbytes[0] = opc;
        host.fbytes[1] = a[23:16];
        host.fbytes[2] = a[15:8];
        host.fbytes[3] = a[7:0];
        host.send(4 + nd, ex, q);
        repeat (8) @(posedge mclk);
        @(negedge mclk);
    endtask
    task unlock();
        send(`SFPE_OP_UNLOCK, 24'h0, -3, 0, 1'b0);
        check(latch, 24'h1);
    endtask
    task run();
        int i;
        check(busy, 24'h1);
        for (i = 0; i < 80000 && busy !== 1'b0; i++)
            @(negedge mclk);
        if (i == 80000) begin
            error_cnt++;
            stop_test();
        end
        check(latch, 24'h0);
    endtask
    task rd_chk(input logic [23:0] a, input bit nx, input logic [23:0] exp);
        @(posedge mclk);
        rd_start <= 1'b1;
        rd_start_addr <= a;
        @(posedge mclk);
        rd_start <= 1'b0;
        rd_next <= nx;
        @(posedge mclk);
        rd_next <= 1'b0;
        @(posedge mclk);
        @(negedge mclk);
        check(nx ? rd_addr : {16'h0, rd_data}, exp);
    endtask
    task t_wrap();
        int k;
        for (k = 0; k < 4; k++) begin
            host.fbytes[4] = {1'b0, 2'(k), 5'h00};
            send(`SFPE_OP_WRAP, 24'h0, 1, 0, 1'b0);
            check(wrap_bits, {2'(k), 1'b0});
            rd_chk(24'h000140 + (24'h8 << k) - 24'h1, 1'b1, 24'h000140);
        end
        send(`SFPE_OP_WRAP, 24'h0, 0, 0, 1'b0);
        check(wrap_bits, 24'h6);
        host.fbytes[4] = 8'h10;
        send(`SFPE_OP_WRAP, 24'h0, 1, 0, 1'b0);
        check(wrap_bits, 24'h1);
        rd_chk(24'h0001ff, 1'b1, 24'h000200);
    endtask
    task t_refuse();
        host.fbytes[4] = 8'h00;
        send(`SFPE_OP_PROG, 24'h000010, 1, 0, 1'b0);
        check(busy, 24'h0);
        unlock();
        send(`SFPE_OP_QPROG, 24'h000010, 1, 0, 1'b1);
        check(busy, 24'h0);
        @(posedge mclk);
        prot <= 5'h07;
        send(`SFPE_OP_UNIT, 24'h000000, 0, 0, 1'b0);
        check(busy, 24'h0);
        send(`SFPE_OP_PROG, 24'h000010, 1, 0, 1'b0);
        check(busy, 24'h0);
        @(posedge mclk);
        prot <= 5'h00;
        quad_en <= 1'b1;
        send(`SFPE_OP_UNIT, 24'h000000, -1, 7, 1'b0);
        check(busy, 24'h0);
        send(`SFPE_OP_PROG, 24'h000010, 1, 7, 1'b0);
        check(busy, 24'h0);
    endtask
    task t_erase_prog();
        int i;
        unlock();
        send(`SFPE_OP_BLK64, 24'h00abcd, 0, 0, 1'b0);
        run();
        rd_chk(24'h000000, 1'b0, 24'hff);
        rd_chk(24'h00ffff, 1'b0, 24'hff);
        host.fbytes[4] = 8'ha1;
        host.fbytes[5] = 8'ha2;
        host.fbytes[6] = 8'ha3;
        unlock();
        send(`SFPE_OP_PROG, 24'h0000fe, 3, 0, 1'b0);
        run();
        rd_chk(24'h0000fe, 1'b0, 24'ha1);
        rd_chk(24'h000000, 1'b0, 24'ha3);
        rd_chk(24'h000001, 1'b0, 24'hff);
        host.fbytes[4] = 8'h5a;
        unlock();
        send(`SFPE_OP_QPROG, 24'h001000, 1, 0, 1'b1);
        run();
        rd_chk(24'h001000, 1'b0, 24'h5a);
        for (i = 4; i < 261; i++)
            host.fbytes[i] = (i == 4) ? 8'h00 : 8'h81;
        unlock();
        send(`SFPE_OP_PROG, 24'h000300, 257, 0, 1'b0);
        run();
        rd_chk(24'h000300, 1'b0, 24'h81);
        unlock();
        send(`SFPE_OP_UNIT, 24'h000abc, 0, 0, 1'b0);
        run();
        rd_chk(24'h0000fe, 1'b0, 24'hff);
        rd_chk(24'h001000, 1'b0, 24'h5a);
        unlock();
        send(`SFPE_OP_BLK32, 24'h007fff, 0, 0, 1'b0);
        run();
        rd_chk(24'h001000, 1'b0, 24'hff);
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        srst <= 1'b0;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        check(busy, 24'h0);
        check(latch, 24'h0);
        check(wrap_bits, 24'h1);
        t_wrap();
        t_refuse();
        t_erase_prog();
        stop_test();
    end
endmodule
